// File: design/ffp_top.sv
// feedback word processing: two sync-link paths and one readout path
// assumes sync word and its strobe arrive from a pin; readout word from same-clock logic
// How it works
// - sync-link feedback words are 16 bits, layout set by sender.
// - readout word is 32 bits: 16 two-bit pairs, one per integrator.
// - without extended channels only the lowest eight pairs are valid.
// - multistate uses both pair bits; otherwise only the low bit.
// - sync A, sync B and readout each have their own independent processing chain.
// - sync paths A and B share the word but keep own settings.
// - raw selections skip shift, mask and offset; raw readout still has invalid pairs and bits cleared.
// - processed path right-shifts; 0..15 sync, 0..31 readout.
// - then masks with length ones; length 1..16.
// - then adds offset 0..4095 giving the result.
// - config blocks the sequencer until done.
// - settings change at run time between feedback operations.
// - unconfigured processed path passes the word as raw.
// - legacy forwarder code maps to A, decoder code to B.
// - sync processing applies whatever remote unit sent the word.
`timescale 1ns/1ps
module ffp_top (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          clk_en_i,
  // sync link (pins)
  input  wire logic [ffp_pkg::SYNC_W-1:0]    sync_word_i,
  input  wire logic                          sync_valid_i,
  // readout unit (same clock)
  input  wire logic [ffp_pkg::READOUT_W-1:0] readout_word_i,
  input  wire logic                          readout_valid_i,
  input  wire logic                          extended_channels_i,
  input  wire logic                          multistate_discrimination_i,
  // set_processing_instr
  input  wire logic                          cfg_req_i,
  input  wire ffp_pkg::ffp_cfg_cmd_t         cfg_cmd_i,
  output logic                               cfg_busy_o,
  output logic                               cfg_done_o,
  output logic                               cfg_error_o,
  // feedback_read_instr / conditional_table_play_instr
  input  wire logic                          fb_req_i,
  input  wire ffp_pkg::ffp_source_t          fb_source_i,
  output logic                               fb_valid_o,
  output logic [ffp_pkg::RES_W-1:0]          fb_result_o,
  output logic                               fb_error_o
);
  // ========================================
  // state
  typedef struct packed {
    ffp_pkg::ffp_state_t              fsm;
    logic [3:0]                       cnt;
    ffp_pkg::ffp_cfg_cmd_t            pend;
    ffp_pkg::ffp_cfg_t                cfg_a;
    ffp_pkg::ffp_cfg_t                cfg_b;
    ffp_pkg::ffp_cfg_t                cfg_r;
    logic [ffp_pkg::SYNC_W-1:0]       sync_word;
    logic [ffp_pkg::READOUT_W-1:0]    ro_word;
    logic                             cfg_busy;
    logic                             cfg_done;
    logic                             cfg_error;
    logic                             fb_valid;
    logic [ffp_pkg::RES_W-1:0]        fb_result;
    logic                             fb_error;
  } ffp_top_state_t;

  ffp_top_state_t state_reg;
  ffp_top_state_t state_next;

  logic [ffp_pkg::SYNC_W:0]      sync_in;
  logic [ffp_pkg::RES_W-1:0]     res_a;
  logic [ffp_pkg::RES_W-1:0]     res_b;
  logic [ffp_pkg::RES_W-1:0]     res_r;
  logic [ffp_pkg::READOUT_W-1:0] ro_clean;

  // ========================================
  // helpers
  function automatic logic cfg_legal(input ffp_pkg::ffp_cfg_cmd_t c);
    logic [ffp_pkg::SHIFT_W-1:0] smax;
    smax = (c.path == ffp_pkg::PATH_READOUT) ? ffp_pkg::RO_SHIFT_MAX : ffp_pkg::SYNC_SHIFT_MAX;
    cfg_legal = (c.path == ffp_pkg::PATH_SYNC_A || c.path == ffp_pkg::PATH_SYNC_B
                 || c.path == ffp_pkg::PATH_READOUT)
                && (c.shift <= smax)
                && (c.length >= ffp_pkg::LEN_MIN) && (c.length <= ffp_pkg::LEN_MAX);
  endfunction

  function automatic ffp_pkg::ffp_cfg_t to_cfg(input ffp_pkg::ffp_cfg_cmd_t c);
    to_cfg = '{configured: 1'b1, shift: c.shift, length: c.length, offset: c.offset};
  endfunction

  // ========================================
  // sync link capture
  ffp_sync #(.W(ffp_pkg::SYNC_W + 1)) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({sync_valid_i, sync_word_i}),
    .q_o       (sync_in)
  );

  // ========================================
  // readout word cleanup: invalid pairs and unused high bits forced to zero
  always_comb begin
    ro_clean = '0;
    for (int p = 0; p < ffp_pkg::PAIRS; p++) begin
      if (extended_channels_i || p < ffp_pkg::PAIRS_RED) begin
        ro_clean[2*p]   = state_reg.ro_word[2*p];
        ro_clean[2*p+1] = multistate_discrimination_i & state_reg.ro_word[2*p+1];
      end
    end
  end

  // ========================================
  // independent processing chains
  ffp_path #(.WORD_W(ffp_pkg::SYNC_W)) u_path_a (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .word_i    (state_reg.sync_word),
    .cfg_i     (state_reg.cfg_a),
    .result_o  (res_a)
  );

  ffp_path #(.WORD_W(ffp_pkg::SYNC_W)) u_path_b (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .word_i    (state_reg.sync_word),
    .cfg_i     (state_reg.cfg_b),
    .result_o  (res_b)
  );

  ffp_path #(.WORD_W(ffp_pkg::READOUT_W)) u_path_r (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .word_i    (ro_clean),
    .cfg_i     (state_reg.cfg_r),
    .result_o  (res_r)
  );

  // ========================================
  // next state
  always_comb begin
    state_next          = state_reg;
    state_next.cfg_done = 1'b0;
    state_next.fb_valid = 1'b0;
    state_next.fb_error = 1'b0;

    // latest received words
    if (sync_in[ffp_pkg::SYNC_W]) begin
      state_next.sync_word = sync_in[ffp_pkg::SYNC_W-1:0];
    end
    if (readout_valid_i) begin
      state_next.ro_word = readout_word_i;
    end

    // configuration: blocking, settings land one cycle before done
    case (state_reg.fsm)
      ffp_pkg::FFP_IDLE: begin
        if (cfg_req_i) begin
          if (cfg_legal(cfg_cmd_i)) begin
            state_next.pend     = cfg_cmd_i;
            state_next.cnt      = ffp_pkg::CFG_CNT;
            state_next.cfg_busy = 1'b1;
            state_next.fsm      = ffp_pkg::FFP_BUSY;
          end else begin
            state_next.cfg_error = 1'b1;
            state_next.cfg_done  = 1'b1;
          end
        end
      end
      ffp_pkg::FFP_BUSY: begin
        if (state_reg.cnt == 4'h1) begin
          // path results re-register one cycle later, so busy covers that cycle too
          case (state_reg.pend.path)
            ffp_pkg::PATH_SYNC_A: state_next.cfg_a = to_cfg(state_reg.pend);
            ffp_pkg::PATH_SYNC_B: state_next.cfg_b = to_cfg(state_reg.pend);
            default:              state_next.cfg_r = to_cfg(state_reg.pend);
          endcase
          state_next.cnt = 4'h0;
        end else if (state_reg.cnt == 4'h0) begin
          state_next.cfg_busy  = 1'b0;
          state_next.cfg_done  = 1'b1;
          state_next.cfg_error = 1'b0;
          state_next.fsm       = ffp_pkg::FFP_IDLE;
        end else begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      default: begin
        state_next.fsm = ffp_pkg::FFP_IDLE;
      end
    endcase

    // feedback request: answered next cycle
    if (fb_req_i) begin
      state_next.fb_valid = 1'b1;
      case (fb_source_i)
        ffp_pkg::FFP_SYNC_RAW:     state_next.fb_result = ffp_pkg::RES_W'(state_reg.sync_word);
        ffp_pkg::FFP_READOUT_RAW:  state_next.fb_result = ro_clean;
        ffp_pkg::FFP_SYNC_PATH_A,
        ffp_pkg::FFP_LEGACY_FWD:   state_next.fb_result = res_a;
        ffp_pkg::FFP_SYNC_PATH_B,
        ffp_pkg::FFP_LEGACY_DEC:   state_next.fb_result = res_b;
        ffp_pkg::FFP_READOUT_PROC: state_next.fb_result = res_r;
        default: begin
          state_next.fb_result = '0;
          state_next.fb_error  = 1'b1;
        end
      endcase
    end
  end

  // ========================================
  // registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg       <= '0;
      state_reg.fsm   <= ffp_pkg::FFP_IDLE;
      state_reg.cfg_a <= ffp_pkg::CFG_RESET;
      state_reg.cfg_b <= ffp_pkg::CFG_RESET;
      state_reg.cfg_r <= ffp_pkg::CFG_RESET;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign cfg_busy_o  = state_reg.cfg_busy;
  assign cfg_done_o  = state_reg.cfg_done;
  assign cfg_error_o = state_reg.cfg_error;
  assign fb_valid_o  = state_reg.fb_valid;
  assign fb_result_o = state_reg.fb_result;
  assign fb_error_o  = state_reg.fb_error;
endmodule // ffp_top

// File: design/ffp_pkg.sv
// package of shared constants and types for feedback word processing
// assumes a single core clock domain; no register bus, all controls are ports
package ffp_pkg;
  // ========================================
  // widths
  localparam int SYNC_W     = 16;
  localparam int READOUT_W  = 32;
  localparam int PAIRS      = 16;
  localparam int PAIRS_RED  = 8;
  localparam int SHIFT_W    = 5;
  localparam int LEN_W      = 5;
  localparam int OFS_W      = 12;
  localparam int RES_W      = 32;
  localparam int SEL_W      = 3;
  localparam int PATH_W     = 2;

  // ========================================
  // limits
  localparam logic [SHIFT_W-1:0] SYNC_SHIFT_MAX = 5'h0F;
  localparam logic [SHIFT_W-1:0] RO_SHIFT_MAX   = 5'h1F;
  localparam logic [LEN_W-1:0]   LEN_MIN        = 5'h01;
  localparam logic [LEN_W-1:0]   LEN_MAX        = 5'h10;
  localparam logic [OFS_W-1:0]   OFS_MAX        = 12'hFFF;

  // ========================================
  // timing: settings land after this many cycles; busy holds one cycle more, blocking the sequencer
  localparam int CFG_NS     = 40;
  localparam int CLK_NS     = 20;
  localparam int CFG_CYCLES = (CFG_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CFG_CNT = 4'(CFG_CYCLES);

  // ========================================
  // source codes
  typedef enum logic [SEL_W-1:0] {
    FFP_SYNC_RAW      = 3'h0,
    FFP_SYNC_PATH_A   = 3'h1,
    FFP_SYNC_PATH_B   = 3'h2,
    FFP_READOUT_RAW   = 3'h3,
    FFP_READOUT_PROC  = 3'h4,
    FFP_LEGACY_FWD    = 3'h5,
    FFP_LEGACY_DEC    = 3'h6
  } ffp_source_t;

  // path select operand codes
  localparam logic [PATH_W-1:0] PATH_SYNC_A  = 2'h0;
  localparam logic [PATH_W-1:0] PATH_SYNC_B  = 2'h1;
  localparam logic [PATH_W-1:0] PATH_READOUT = 2'h2;

  typedef struct packed {
    logic               configured;
    logic [SHIFT_W-1:0] shift;
    logic [LEN_W-1:0]   length;
    logic [OFS_W-1:0]   offset;
  } ffp_cfg_t;

  localparam ffp_cfg_t CFG_RESET = '{configured: 1'b0, shift: 5'h00, length: 5'h10, offset: 12'h000};

  typedef struct packed {
    logic [PATH_W-1:0]  path;
    logic [SHIFT_W-1:0] shift;
    logic [LEN_W-1:0]   length;
    logic [OFS_W-1:0]   offset;
  } ffp_cfg_cmd_t;

  typedef enum logic [1:0] {
    FFP_IDLE = 2'b01,
    FFP_BUSY = 2'b10
  } ffp_state_t;
endpackage

// File: design/ffp_path.sv
// one processed feedback path: shift, length mask, offset
// assumes the word and settings are stable on the same clock; result registered
`timescale 1ns/1ps
module ffp_path #(
  parameter int WORD_W = 16
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       clk_en_i,
  input  wire logic [WORD_W-1:0]          word_i,
  input  wire ffp_pkg::ffp_cfg_t          cfg_i,
  output logic [ffp_pkg::RES_W-1:0]       result_o
);
  typedef struct packed {
    logic [ffp_pkg::RES_W-1:0] result;
  } ffp_path_state_t;

  ffp_path_state_t state_reg;
  ffp_path_state_t state_next;

  // mask of length ones
  function automatic logic [ffp_pkg::RES_W-1:0] len_mask(input logic [ffp_pkg::LEN_W-1:0] len);
    len_mask = (32'h00000001 << len) - 32'h00000001;
  endfunction

  always_comb begin
    logic [ffp_pkg::RES_W-1:0] wide;
    wide       = ffp_pkg::RES_W'(word_i);
    state_next = state_reg;
    if (!cfg_i.configured) begin
      state_next.result = wide;
    end else begin
      state_next.result = ((wide >> cfg_i.shift) & len_mask(cfg_i.length))
                          + ffp_pkg::RES_W'(cfg_i.offset);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign result_o = state_reg.result;
endmodule // ffp_path

// File: design/ffp_sync.sv
// two-flop synchroniser for pin-side inputs, vector wide
// assumes a single destination clock; first stage is read only by the second
`timescale 1ns/1ps
module ffp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] d_i,
  output logic [W-1:0]      q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ffp_sync_state_t;

  ffp_sync_state_t state_reg;
  ffp_sync_state_t state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = d_i;
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign q_o = state_reg.s2;
endmodule // ffp_sync

// File: tb/ffp_chk.sv
// port checker for feedback word processing
// assumes bound into ffp_top; one clock, async reset
`timescale 1ns/1ps
module ffp_chk (
  input wire logic                          sys_clk_i,
  input wire logic                          reset_i,
  input wire logic                          clk_en_i,
  input wire logic                          extended_channels_i,
  input wire logic                          multistate_discrimination_i,
  input wire logic                          cfg_req_i,
  input wire ffp_pkg::ffp_cfg_cmd_t         cfg_cmd_i,
  input wire logic                          cfg_busy_o,
  input wire logic                          cfg_done_o,
  input wire logic                          cfg_error_o,
  input wire logic                          fb_req_i,
  input wire ffp_pkg::ffp_source_t          fb_source_i,
  input wire logic                          fb_valid_o,
  input wire logic [ffp_pkg::RES_W-1:0]     fb_result_o,
  input wire logic                          fb_error_o
);
  // ====
  // helpers
  logic legal;
  logic take_cfg;
  logic take_fb;
  logic ro_raw;
  assign legal = cfg_cmd_i.path != 2'h3 && (cfg_cmd_i.path == 2'h2 || cfg_cmd_i.shift <= 5'h0F)
                 && cfg_cmd_i.length != 5'h00 && cfg_cmd_i.length <= 5'h10;
  assign take_cfg = clk_en_i && cfg_req_i && !cfg_busy_o;
  assign take_fb = clk_en_i && fb_req_i;
  assign ro_raw = take_fb && fb_source_i == ffp_pkg::FFP_READOUT_RAW;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ====
  // assertions
  cfg_legal_a: assert property (take_cfg && legal |=> cfg_busy_o [*3] ##1
    (cfg_done_o && !cfg_busy_o && !cfg_error_o)) else $error("legal config timing wrong");
  cfg_refuse_a: assert property (take_cfg && !legal |=> cfg_done_o && cfg_error_o && !cfg_busy_o)
    else $error("bad config not refused");
  done_pulse_a: assert property (cfg_done_o |=> !cfg_done_o) else $error("done longer than a cycle");
  fb_answer_a: assert property (take_fb |=> fb_valid_o) else $error("no feedback answer");
  fb_cause_a: assert property (fb_valid_o |-> $past(take_fb)) else $error("answer without request");
  bad_code_a: assert property (take_fb && fb_source_i == 3'h7 |=> fb_error_o && fb_result_o == 32'h0)
    else $error("illegal source not flagged");
  result_hold_a: assert property (!take_fb |=> $stable(fb_result_o)) else $error("result moved idle");
  raw_sync_a: assert property (take_fb && fb_source_i == ffp_pkg::FFP_SYNC_RAW
    |=> fb_result_o[31:16] == 16'h0000) else $error("raw sync wider than 16");
  ro_narrow_a: assert property (ro_raw && !extended_channels_i |=> fb_result_o[31:16] == 16'h0000)
    else $error("upper pairs not cleared");
  ro_low_a: assert property (ro_raw && !multistate_discrimination_i
    |=> (fb_result_o & 32'hAAAAAAAA) == 32'h0) else $error("upper pair bit kept");
endmodule // ffp_chk

bind ffp_top ffp_chk ffp_chk_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
  .extended_channels_i(extended_channels_i), .multistate_discrimination_i(multistate_discrimination_i),
  .cfg_req_i(cfg_req_i), .cfg_cmd_i(cfg_cmd_i), .cfg_busy_o(cfg_busy_o), .cfg_done_o(cfg_done_o),
  .cfg_error_o(cfg_error_o), .fb_req_i(fb_req_i), .fb_source_i(fb_source_i), .fb_valid_o(fb_valid_o),
  .fb_result_o(fb_result_o), .fb_error_o(fb_error_o));

// File: tb/ffp_seq_model.sv
// sequencer model: issues processing setup and feedback operations
// assumes tasks are called from the bench; drives on rising edges
`timescale 1ns/1ps
module ffp_seq_model (
  input  wire logic                      sys_clk_i,
  output logic                           cfg_req_o,
  output ffp_pkg::ffp_cfg_cmd_t          cfg_cmd_o,
  input  wire logic                      cfg_done_i,
  input  wire logic                      cfg_error_i,
  output logic                           fb_req_o,
  output ffp_pkg::ffp_source_t           fb_source_o,
  input  wire logic                      fb_valid_i,
  input  wire logic [ffp_pkg::RES_W-1:0] fb_result_i,
  input  wire logic                      fb_error_i
);
  // ====
  // idle values
  initial begin
    cfg_req_o = 1'b0;
    cfg_cmd_o = '0;
    fb_req_o = 1'b0;
    fb_source_o = ffp_pkg::FFP_SYNC_RAW;
  end
  // ====
  // setup instruction, blocks until done
  task automatic cfg_op(input logic [1:0] p, input logic [4:0] s, input logic [4:0] l,
                        input logic [11:0] o, output logic e);
    int n;
    @(posedge sys_clk_i);
    cfg_req_o <= 1'b1;
    cfg_cmd_o <= '{path: p, shift: s, length: l, offset: o};
    @(posedge sys_clk_i);
    cfg_req_o <= 1'b0;
    cfg_cmd_o <= ~cfg_cmd_o; // released operand no longer valid
    n = 0;
    while (cfg_done_i !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      n++;
    end
    e = (n < 8) ? cfg_error_i : 1'bx;
  endtask
  // ====
  // feedback operation, source as first operand
  task automatic fb_op(input logic [2:0] s, output logic [31:0] r, output logic e);
    @(posedge sys_clk_i);
    fb_req_o <= 1'b1;
    fb_source_o <= ffp_pkg::ffp_source_t'(s);
    @(posedge sys_clk_i);
    fb_req_o <= 1'b0;
    fb_source_o <= ffp_pkg::ffp_source_t'(~s);
    @(posedge sys_clk_i);
    r = (fb_valid_i === 1'b1) ? fb_result_i : 32'hXXXXXXXX;
    e = fb_error_i;
  endtask
endmodule // ffp_seq_model

// File: tb/ffp_top_test.sv
// self-checking bench for feedback word processing
// assumes ffp_top, ffp_seq_model and bound checker
`timescale 1ns/1ps
module ffp_top_test;
  logic                  sys_clk_i, reset_i, clk_en_i, sync_valid_i, readout_valid_i, ext_i, ms_i;
  logic [15:0]           sync_word_i;
  logic [31:0]           readout_word_i, fb_result_o;
  logic                  cfg_req_i, cfg_busy_o, cfg_done_o, cfg_error_o, fb_req_i, fb_valid_o, fb_error_o;
  ffp_pkg::ffp_cfg_cmd_t cfg_cmd_i;
  ffp_pkg::ffp_source_t  fb_source_i;
  int                    n_errors, cmp_count, cyc;
  ffp_top ffp_top_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .sync_word_i(sync_word_i), .sync_valid_i(sync_valid_i), .readout_word_i(readout_word_i),
    .readout_valid_i(readout_valid_i), .extended_channels_i(ext_i), .multistate_discrimination_i(ms_i),
    .cfg_req_i(cfg_req_i), .cfg_cmd_i(cfg_cmd_i), .cfg_busy_o(cfg_busy_o), .cfg_done_o(cfg_done_o),
    .cfg_error_o(cfg_error_o), .fb_req_i(fb_req_i), .fb_source_i(fb_source_i), .fb_valid_o(fb_valid_o),
    .fb_result_o(fb_result_o), .fb_error_o(fb_error_o));
  ffp_seq_model ffp_seq_model_inst (.sys_clk_i(sys_clk_i), .cfg_req_o(cfg_req_i), .cfg_cmd_o(cfg_cmd_i),
    .cfg_done_i(cfg_done_o), .cfg_error_i(cfg_error_o), .fb_req_o(fb_req_i), .fb_source_o(fb_source_i),
    .fb_valid_i(fb_valid_o), .fb_result_i(fb_result_o), .fb_error_i(fb_error_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ====
  // helpers
  function automatic logic [31:0] px(logic [31:0] w, int s, int l, logic [11:0] o);
    return ((w >> s) & ((32'h1 << l) - 32'h1)) + {20'h0, o};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [2:0] s, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    ffp_seq_model_inst.fb_op(s, r, e);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic cf(input logic [1:0] p, input logic [4:0] s, input logic [4:0] l, input logic [11:0] o,
                    input logic x);
    logic e;
    ffp_seq_model_inst.cfg_op(p, s, l, o, e);
    chk({31'h0, e}, {31'h0, x});
  endtask
  // word held on pins only while valid; afterwards pins show its inverse
  task automatic sy(input logic [15:0] w);
    @(posedge sys_clk_i);
    sync_word_i <= w;
    sync_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    sync_valid_i <= 1'b0;
    sync_word_i <= ~w;
    repeat (5) @(posedge sys_clk_i);
  endtask
  task automatic ro(input logic [31:0] w);
    @(posedge sys_clk_i);
    readout_word_i <= w;
    readout_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    readout_valid_i <= 1'b0;
    readout_word_i <= ~w;
    repeat (2) @(posedge sys_clk_i);
  endtask
  // ====
  // scenarios
  task automatic t_raw();
    logic [2:0] sc [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    sy(16'hA5C3);
    ro(32'hDEADBEEF);
    foreach (sc[i]) rd(sc[i], 32'h0000A5C3);
    rd(3'h3, 32'hDEADBEEF);
    rd(3'h4, 32'hDEADBEEF);
  endtask
  task automatic t_proc();
    cf(2'h0, 5'h0F, 5'h01, 12'hFFF, 1'b0);
    cf(2'h1, 5'h04, 5'h10, 12'h000, 1'b0);
    cf(2'h2, 5'h1F, 5'h01, 12'h007, 1'b0);
    sy(16'h8421);
    ro(32'h80000001);
    rd(3'h1, px(32'h8421, 15, 1, 12'hFFF));
    rd(3'h5, px(32'h8421, 15, 1, 12'hFFF));
    rd(3'h2, px(32'h8421, 4, 16, 12'h000));
    rd(3'h6, px(32'h8421, 4, 16, 12'h000));
    rd(3'h0, 32'h00008421);
    rd(3'h4, px(32'h80000001, 31, 1, 12'h007));
    rd(3'h3, 32'h80000001);
  endtask
  task automatic t_runtime();
    cf(2'h0, 5'h00, 5'h10, 12'h000, 1'b0);
    rd(3'h1, 32'h00008421);
    cf(2'h0, 5'h02, 5'h04, 12'h005, 1'b0);
    rd(3'h1, px(32'h8421, 2, 4, 12'h005));
    rd(3'h2, px(32'h8421, 4, 16, 12'h000));
    // frozen clock enable: a word strobed meanwhile is never taken
    clk_en_i <= 1'b0;
    sy(16'h1234);
    clk_en_i <= 1'b1;
    rd(3'h0, 32'h00008421);
  endtask
  task automatic t_refuse();
    cf(2'h3, 5'h00, 5'h01, 12'h000, 1'b1);
    cf(2'h0, 5'h10, 5'h01, 12'h000, 1'b1);
    cf(2'h1, 5'h00, 5'h00, 12'h000, 1'b1);
    cf(2'h2, 5'h00, 5'h11, 12'h000, 1'b1);
    rd(3'h1, px(32'h8421, 2, 4, 12'h005));
    rd(3'h4, px(32'h80000001, 31, 1, 12'h007));
    cf(2'h1, 5'h04, 5'h10, 12'h000, 1'b0);
  endtask
  task automatic t_pairs();
    logic [31:0] r;
    logic        e;
    ext_i <= 1'b0;
    ms_i <= 1'b0;
    ro(32'hFFFFFFFF);
    rd(3'h3, 32'h00005555);
    ms_i <= 1'b1;
    rd(3'h3, 32'h0000FFFF);
    ext_i <= 1'b1;
    ms_i <= 1'b0;
    rd(3'h3, 32'h55555555);
    ms_i <= 1'b1;
    ffp_seq_model_inst.fb_op(3'h7, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  // ====
  // run control
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("[ERR] %0t run too long", $time);
      conclude();
    end
  end
  initial begin
    {reset_i, clk_en_i, ext_i, ms_i} = 4'hF;
    {sync_valid_i, readout_valid_i, sync_word_i, readout_word_i} = '0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_raw();
    t_proc();
    t_runtime();
    t_refuse();
    t_pairs();
    conclude();
  end
endmodule // ffp_top_test
